// ---- core_mem_partner.sv ----
// Program memory and data register file beside the core execution slice.
// Assumes the testbench loads prog and data before reset is released.
module core_mem_partner (
    // Clock
    input wire logic i_clk,
    // Program memory
    input wire logic [core_pkg::PC_W-1:0] i_pc,
    output logic [core_pkg::INSTR_W-1:0] o_instr,
    // Data file
    input wire logic [core_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    import core_pkg::*;
    logic [INSTR_W-1:0] prog [0:255];
    logic [7:0] data [0:4095];
    assign o_instr = prog[i_pc[7:0]];
    initial o_rdata = 8'h5a;
    // Read data is valid only in the cycle after the strobe, otherwise it flips
    always @(posedge i_clk) begin
        o_rdata <= i_rd ? data[i_addr] : ~o_rdata;
        if (i_wr) begin
            data[i_addr] <= i_wdata;
        end
    end
endmodule

// ---- core_pkg.sv ----
// Shared constants for the core execution slice: opcodes, fields, SFR map, flags.
// Assumes a single clock domain and a 16-bit program word.
package core_pkg;
    localparam int PC_W = 21;
    localparam int ADDR_W = 12;
    localparam int INSTR_W = 16;

    typedef enum logic [1:0] {
        first_phase,
        second_phase,
        third_phase,
        fourth_phase
    } phase_e;

    typedef enum logic [3:0] {
        op_nop,
        add_literal_to_acc,
        add_acc_to_file,
        clear_file_op,
        op_bit_set,
        op_bit_clr,
        op_bit_tgl,
        op_call,
        op_return,
        interrupt_return
    } op_e;

    // Opcode fields
    localparam logic [7:0] OPC_ADD_LIT = 8'h0f;
    localparam logic [5:0] OPC_ADD_FILE = 6'h09;
    localparam logic [6:0] OPC_CLEAR = 7'h35;
    localparam logic [3:0] OPC_BIT_SET = 4'h8;
    localparam logic [3:0] OPC_BIT_CLR = 4'h9;
    localparam logic [3:0] OPC_BIT_TGL = 4'h7;
    localparam logic [6:0] OPC_CALL = 7'h76;
    localparam logic [14:0] OPC_RETURN = 15'h0009;
    localparam logic [14:0] OPC_INT_RETURN = 15'h0008;
    localparam logic [15:0] NOP_WORD = 16'h0000;

    // Field positions
    localparam int D_BIT = 9;
    localparam int A_BIT = 8;
    localparam int CALL_S_BIT = 8;
    localparam int RET_S_BIT = 0;

    // Status flag positions
    localparam int C_POS = 0;
    localparam int DC_POS = 1;
    localparam int Z_POS = 2;
    localparam int OV_POS = 3;
    localparam int N_POS = 4;
    localparam logic [4:0] FLAGS_ALL = 5'h1f;
    localparam logic [4:0] FLAGS_Z = 5'h04;
    localparam logic [7:0] STATUS_CLEARED = 8'h04;

    // Internal special function register map
    localparam logic [11:0] ADDR_STATUS = 12'hfe0;
    localparam logic [11:0] ADDR_WORKING_ACCUMULATOR = 12'hfe1;
    localparam logic [11:0] ADDR_BSR = 12'hfe2;
    localparam logic [11:0] ADDR_PCL = 12'hfe3;
    localparam logic [11:0] ADDR_LATH = 12'hfe4;
    localparam logic [11:0] ADDR_LATU = 12'hfe5;
    localparam logic [11:0] ADDR_EVT = 12'hfe6;
    localparam logic [11:0] ADDR_CTRL = 12'hfe7;
    localparam int CTRL_ALT_BIT = 0;

    localparam logic [20:0] IRQ_VECTOR = 21'h000010;
endpackage

// ---- core_sfr_fast_stack_add.sv ----
// Execution slice of an 8-bit core: phase sequencer, SFR side effects,
// fast shadow stack and the two add instructions.
// Assumes program memory answers combinationally at O_PC and the data file
// returns read data the cycle after O_FILE_RD.
module core_sfr_fast_stack_add (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // Alternate phase clock pin
    input wire logic I_ALT_TICK,
    // Program memory
    input wire logic [core_pkg::INSTR_W-1:0] I_INSTR,
    output logic [core_pkg::PC_W-1:0] O_PC,
    // Data register file
    output logic [core_pkg::ADDR_W-1:0] O_FILE_ADDR,
    output logic O_FILE_RD,
    output logic O_FILE_WR,
    output logic [7:0] O_FILE_WDATA,
    input wire logic [7:0] I_FILE_RDATA,
    // Interrupt entry and hardware events
    input wire logic I_IRQ,
    output logic O_IRQ_ACK,
    input wire logic [7:0] I_HW_EVT,
    // Observation
    output logic [1:0] O_PHASE,
    output logic [7:0] O_WORKING_ACCUMULATOR,
    output logic [7:0] O_STATUS
);
    import core_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic filt;
        logic filt_d;
        phase_e phase;
        logic [15:0] ir;
        logic flush;
        logic nop_cyc;
        logic rd_pend;
        logic irq_pend;
        logic irq_ack;
        logic [7:0] operand;
        logic [7:0] result;
        logic [4:0] flags;
        logic [4:0] mask;
        logic [7:0] working_accumulator;
        logic [7:0] bank_select_reg;
        logic [7:0] status;
        logic [7:0] pc_high_byte;
        logic [7:0] pc_low_byte;
        logic [7:0] lath;
        logic [7:0] evt;
        logic [7:0] evt_pend;
        logic [7:0] ctrl;
        logic [4:0] pc_upper_byte;
        logic [4:0] latu;
        logic [7:0] sh_working_accumulator;
        logic [7:0] sh_bsr;
        logic [7:0] sh_status;
        logic [20:0] ret_pc;
    } state_s;

    state_s st;
    state_s next_st;

    op_e op;
    logic tick;
    logic dbit;
    logic fast;
    logic [7:0] fld;
    logic [11:0] file_addr;
    logic reads_file;
    logic writes_file;
    logic is_int;
    logic [7:0] sfr_rdata;
    logic [7:0] opnd;
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] bit_mask;
    logic [20:0] pc;
    logic [20:0] pc_inc;
    logic [7:0] stat_base;
    logic pc_written;

    // Phase source: every clock, or a filtered edge of the alternate pin
    assign tick = st.ctrl[CTRL_ALT_BIT] ? (st.filt & ~st.filt_d) : 1'h1;

    assign pc = {st.pc_upper_byte, st.pc_high_byte, st.pc_low_byte};
    assign pc_inc = pc + 21'h000001;
    assign dbit = st.ir[D_BIT];
    assign fld = st.ir[7:0];
    assign fast = (op == op_call) ? st.ir[CALL_S_BIT] : st.ir[RET_S_BIT];
    // Access bank: low half in bank 0, high half in the SFR bank
    assign file_addr = st.ir[A_BIT] ? {st.bank_select_reg[3:0], fld} : {{4{fld[7]}}, fld};
    assign is_int = (file_addr[11:3] == ADDR_STATUS[11:3]);
    assign bit_mask = 8'h01 << st.ir[11:9];

    always_comb begin
        op = op_nop;
        if (st.ir[15:8] == OPC_ADD_LIT) begin
            op = add_literal_to_acc;
        end else if (st.ir[15:10] == OPC_ADD_FILE) begin
            op = add_acc_to_file;
        end else if (st.ir[15:9] == OPC_CLEAR) begin
            op = clear_file_op;
        end else if (st.ir[15:12] == OPC_BIT_SET) begin
            op = op_bit_set;
        end else if (st.ir[15:12] == OPC_BIT_CLR) begin
            op = op_bit_clr;
        end else if (st.ir[15:12] == OPC_BIT_TGL) begin
            op = op_bit_tgl;
        end else if (st.ir[15:9] == OPC_CALL) begin
            op = op_call;
        end else if (st.ir[15:1] == OPC_RETURN) begin
            op = op_return;
        end else if (st.ir[15:1] == OPC_INT_RETURN) begin
            op = interrupt_return;
        end
    end

    assign reads_file = (op == add_acc_to_file) || (op == op_bit_set) ||
                        (op == op_bit_clr) || (op == op_bit_tgl);
    assign writes_file = ((op == add_acc_to_file) && dbit) || (op == clear_file_op) ||
                         (op == op_bit_set) || (op == op_bit_clr) || (op == op_bit_tgl);

    // Shadow registers and PC high/upper bytes have no address here
    always_comb begin
        case (file_addr)
            ADDR_STATUS: sfr_rdata = st.status;
            ADDR_WORKING_ACCUMULATOR: sfr_rdata = st.working_accumulator;
            ADDR_BSR: sfr_rdata = st.bank_select_reg;
            ADDR_PCL: sfr_rdata = st.pc_low_byte;
            ADDR_LATH: sfr_rdata = st.lath;
            ADDR_LATU: sfr_rdata = {3'h0, st.latu};
            ADDR_EVT: sfr_rdata = st.evt;
            ADDR_CTRL: sfr_rdata = st.ctrl;
            default: sfr_rdata = 8'h00;
        endcase
    end

    // External data arrives the cycle after the strobe
    assign opnd = st.rd_pend ? I_FILE_RDATA : st.operand;
    assign sum = {1'h0, st.working_accumulator} + {1'h0, opnd};
    assign half = {1'h0, st.working_accumulator[3:0]} + {1'h0, opnd[3:0]};

    always_comb begin
        next_st = st;
        stat_base = st.status;
        pc_written = 1'h0;
        next_st.irq_ack = 1'h0;
        next_st.sync1 = I_ALT_TICK;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        if (st.sync2 == st.sync3) begin
            next_st.filt = st.sync2;
        end
        next_st.filt_d = st.filt;
        next_st.evt_pend = st.evt_pend | I_HW_EVT;
        if (st.rd_pend) begin
            next_st.operand = I_FILE_RDATA;
            next_st.rd_pend = 1'h0;
        end
        if (tick) begin
            case (st.phase)
                first_phase: begin
                    next_st.phase = second_phase;
                    next_st.evt = st.evt | st.evt_pend | I_HW_EVT;
                    next_st.evt_pend = 8'h00;
                    next_st.ir = st.flush ? NOP_WORD : I_INSTR;
                    next_st.nop_cyc = st.flush;
                    next_st.flush = 1'h0;
                end
                second_phase: begin
                    next_st.phase = third_phase;
                    if (reads_file && is_int) begin
                        next_st.operand = sfr_rdata;
                        if (file_addr == ADDR_PCL) begin
                            next_st.lath = st.pc_high_byte;
                            next_st.latu = st.pc_upper_byte;
                        end
                    end else if (reads_file) begin
                        next_st.rd_pend = 1'h1;
                    end else begin
                        next_st.operand = fld;
                    end
                end
                third_phase: begin
                    next_st.phase = fourth_phase;
                    next_st.mask = 5'h00;
                    next_st.flags = 5'h00;
                    next_st.result = opnd;
                    case (op)
                        add_literal_to_acc, add_acc_to_file: begin
                            next_st.result = sum[7:0];
                            next_st.mask = FLAGS_ALL;
                            next_st.flags[C_POS] = sum[8];
                            next_st.flags[DC_POS] = half[4];
                            next_st.flags[Z_POS] = (sum[7:0] == 8'h00);
                            next_st.flags[OV_POS] = (st.working_accumulator[7] == opnd[7]) &&
                                                    (sum[7] != st.working_accumulator[7]);
                            next_st.flags[N_POS] = sum[7];
                        end
                        clear_file_op: begin
                            next_st.result = 8'h00;
                            next_st.mask = FLAGS_Z;
                            next_st.flags = FLAGS_Z;
                        end
                        op_bit_set: next_st.result = opnd | bit_mask;
                        op_bit_clr: next_st.result = opnd & ~bit_mask;
                        op_bit_tgl: next_st.result = opnd ^ bit_mask;
                        default: ;
                    endcase
                end
                fourth_phase: begin
                    next_st.phase = first_phase;
                    if ((op == add_literal_to_acc) || ((op == add_acc_to_file) && !dbit)) begin
                        next_st.working_accumulator = st.result;
                    end
                    if (writes_file && is_int) begin
                        case (file_addr)
                            ADDR_STATUS: stat_base = st.result;
                            ADDR_WORKING_ACCUMULATOR: next_st.working_accumulator = st.result;
                            ADDR_BSR: next_st.bank_select_reg = st.result;
                            ADDR_PCL: begin
                                next_st.pc_low_byte = st.result;
                                next_st.pc_high_byte = st.lath;
                                next_st.pc_upper_byte = st.latu;
                                pc_written = 1'h1;
                            end
                            ADDR_LATH: next_st.lath = st.result;
                            ADDR_LATU: next_st.latu = st.result[4:0];
                            ADDR_EVT: next_st.evt = st.result;
                            ADDR_CTRL: next_st.ctrl = st.result;
                            default: ;
                        endcase
                    end
                    next_st.status = (stat_base & ~{3'h0, st.mask}) |
                                     {3'h0, st.flags & st.mask};
                    if (pc_written) begin
                        next_st.flush = 1'h1;
                    end else if (op == op_call) begin
                        next_st.ret_pc = pc_inc;
                        {next_st.pc_upper_byte, next_st.pc_high_byte, next_st.pc_low_byte} = {st.latu, st.lath, fld};
                        next_st.flush = 1'h1;
                        if (fast) begin
                            next_st.sh_working_accumulator = st.working_accumulator;
                            next_st.sh_bsr = st.bank_select_reg;
                            next_st.sh_status = st.status;
                        end
                    end else if ((op == op_return) || (op == interrupt_return)) begin
                        {next_st.pc_upper_byte, next_st.pc_high_byte, next_st.pc_low_byte} = st.ret_pc;
                        next_st.flush = 1'h1;
                        if (fast) begin
                            next_st.working_accumulator = st.sh_working_accumulator;
                            next_st.bank_select_reg = st.sh_bsr;
                            next_st.status = st.sh_status;
                        end
                    end else if (st.irq_pend) begin
                        next_st.ret_pc = st.nop_cyc ? pc : pc_inc;
                        {next_st.pc_upper_byte, next_st.pc_high_byte, next_st.pc_low_byte} = IRQ_VECTOR;
                        next_st.flush = 1'h1;
                        next_st.irq_pend = 1'h0;
                        next_st.irq_ack = 1'h1;
                        next_st.sh_working_accumulator = next_st.working_accumulator;
                        next_st.sh_bsr = next_st.bank_select_reg;
                        next_st.sh_status = next_st.status;
                    end else if (!st.nop_cyc) begin
                        {next_st.pc_upper_byte, next_st.pc_high_byte, next_st.pc_low_byte} = pc_inc;
                    end
                end
                default: next_st.phase = first_phase;
            endcase
        end
        // A request in the cycle it is taken stays pending
        if (I_IRQ) begin
            next_st.irq_pend = 1'h1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign O_PC = pc;
    assign O_FILE_ADDR = file_addr;
    assign O_FILE_RD = tick && (st.phase == second_phase) && reads_file && !is_int;
    assign O_FILE_WR = tick && (st.phase == fourth_phase) && writes_file && !is_int;
    assign O_FILE_WDATA = st.result;
    assign O_IRQ_ACK = st.irq_ack;
    assign O_PHASE = st.phase;
    assign O_WORKING_ACCUMULATOR = st.working_accumulator;
    assign O_STATUS = st.status;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RSTN);

    chk_phase_wrap: assert property ((tick && st.phase == fourth_phase) |=>
        (st.phase == first_phase)) else $error("phase did not wrap to first");
    chk_phase_hold: assert property (!tick |=> $stable(st.phase))
        else $error("phase moved without a phase tick");
    chk_clear_status: assert property ((tick && st.phase == fourth_phase &&
        op == clear_file_op && file_addr == ADDR_STATUS) |=> (st.status == STATUS_CLEARED))
        else $error("cleared status does not hold only zero flag");
    chk_rmw_one_bit: assert property ((O_FILE_WR &&
        (op == op_bit_set || op == op_bit_clr || op == op_bit_tgl)) |->
        (((O_FILE_WDATA ^ st.operand) & ~bit_mask) == 8'h00))
        else $error("bit operation changed other bits");
    chk_evt_first: assert property (((st.evt & ~$past(st.evt)) != 8'h00) |->
        ($past(tick) && ($past(st.phase) == first_phase || $past(st.phase) == fourth_phase)))
        else $error("event flag set outside first phase");
    chk_pcl_read: assert property ((tick && st.phase == second_phase && reads_file &&
        file_addr == ADDR_PCL) |=> (st.lath == $past(st.pc_high_byte) && st.latu == $past(st.pc_upper_byte)))
        else $error("low PC read did not capture latches");
    chk_pcl_write: assert property ((tick && st.phase == fourth_phase && writes_file &&
        file_addr == ADDR_PCL) |=> (st.pc_high_byte == $past(st.lath) && st.pc_low_byte == $past(st.result)
        && st.flush)) else $error("low PC write did not load latches");
    chk_nop_second: assert property ((tick && st.flush && st.phase == first_phase) |=>
        (st.ir == NOP_WORD && st.nop_cyc)) else $error("second cycle not a no-operation");
    chk_shadow_load: assert property (st.irq_ack |-> (st.sh_working_accumulator == st.working_accumulator &&
        st.sh_bsr == st.bank_select_reg && st.sh_status == st.status && O_PC == IRQ_VECTOR))
        else $error("interrupt entry did not load shadow");
    chk_fast_restore: assert property ((tick && st.phase == fourth_phase && fast &&
        (op == op_return || op == interrupt_return)) |=>
        (st.working_accumulator == $past(st.sh_working_accumulator) && st.status == $past(st.sh_status)))
        else $error("fast return did not restore shadow");
    chk_add_literal: assert property ((tick && st.phase == fourth_phase &&
        op == add_literal_to_acc) ##1 (st.phase == first_phase) |->
        (st.working_accumulator == $past(st.result)) && (st.status[Z_POS] == (st.working_accumulator == 8'h00)))
        else $error("add literal result or zero flag wrong");

    cov_irq_entry: cover property (st.irq_ack);
    cov_pcl_write: cover property (tick && st.phase == fourth_phase && writes_file &&
        file_addr == ADDR_PCL);
    cov_fast_call: cover property (tick && st.phase == fourth_phase && op == op_call && fast);
    cov_alt_clock: cover property (st.ctrl[CTRL_ALT_BIT] && tick);
endmodule

// ---- core_sfr_fast_stack_add_test.sv ----
// Testbench: runs a fixed program, compares PC, accumulator, status, data.
// Assumes core_mem_partner as program memory and data file.
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module core_sfr_fast_stack_add_test;
    timeunit 1ns;
    timeprecision 100ps;
    import core_pkg::*;
    logic I_CLK, I_RSTN, I_ALT_TICK, I_IRQ, O_FILE_RD, O_FILE_WR, O_IRQ_ACK;
    logic [INSTR_W-1:0] I_INSTR;
    logic [PC_W-1:0] O_PC, pcm, cur, ret;
    logic [ADDR_W-1:0] O_FILE_ADDR;
    logic [7:0] O_FILE_WDATA, I_FILE_RDATA, I_HW_EVT, O_WORKING_ACCUMULATOR, O_STATUS;
    logic [1:0] O_PHASE;
    logic [7:0] w, s, b, lh, lu, evt, ctrl;
    logic [23:0] shadow;
    logic [7:0] mem [0:4095];
    logic nop_next, ack_seen, alt_prev;
    int fail_count, cmp_count, clk_n, alt_cnt, pa, seed;
    localparam logic [20:0] IRQ_PC = 21'h5;
    localparam logic [20:0] EVT_PC = 21'h61;
    localparam logic [20:0] END_PC = 21'h3f;
    localparam logic [7:0] EVT_VAL = 8'ha4;
    // Bank, fast call, event and alternate clock sequence, entered by the PC_LOW_BYTE jump
    logic [15:0] build_a [12] = '{16'h6ae1, 16'h0f03, 16'h26e2, 16'h2745, 16'hed50,
        16'hec60, 16'h80e6, 16'h6ae1, 16'h24e6, 16'h6ae1, 16'h0f01, 16'h26e7};

    core_sfr_fast_stack_add u_dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ALT_TICK(I_ALT_TICK),
        .I_INSTR(I_INSTR), .O_PC(O_PC), .O_FILE_ADDR(O_FILE_ADDR), .O_FILE_RD(O_FILE_RD),
        .O_FILE_WR(O_FILE_WR), .O_FILE_WDATA(O_FILE_WDATA), .I_FILE_RDATA(I_FILE_RDATA),
        .I_IRQ(I_IRQ), .O_IRQ_ACK(O_IRQ_ACK), .I_HW_EVT(I_HW_EVT), .O_PHASE(O_PHASE),
        .O_WORKING_ACCUMULATOR(O_WORKING_ACCUMULATOR), .O_STATUS(O_STATUS));
    core_mem_partner u_mem (.i_clk(I_CLK), .i_pc(O_PC), .o_instr(I_INSTR),
        .i_addr(O_FILE_ADDR), .i_rd(O_FILE_RD), .i_wr(O_FILE_WR),
        .i_wdata(O_FILE_WDATA), .o_rdata(I_FILE_RDATA));

    initial begin
        I_CLK = 1'b0;
        forever #12.5 I_CLK = ~I_CLK;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Alternate tick source: one rising edge every ten clocks
    always @(posedge I_CLK) begin
        clk_n <= clk_n + 1;
        alt_cnt <= (alt_cnt == 4) ? 0 : alt_cnt + 1;
        if (alt_cnt == 4) begin
            I_ALT_TICK <= ~I_ALT_TICK;
        end
        if (O_IRQ_ACK === 1'b1) begin
            ack_seen <= 1'b1;
        end
        if (clk_n == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    function automatic logic [7:0] rdf(input logic [11:0] ad);
        case (ad)
            ADDR_STATUS: return s;
            ADDR_WORKING_ACCUMULATOR: return w;
            ADDR_BSR: return b;
            ADDR_PCL: begin
                lh = cur[15:8];
                lu = {3'h0, cur[20:16]};
                return cur[7:0];
            end
            ADDR_LATH: return lh;
            ADDR_LATU: return lu;
            ADDR_EVT: return evt;
            ADDR_CTRL: return ctrl;
            default: return mem[ad];
        endcase
    endfunction

    task automatic wrf(input logic [11:0] ad, input logic [7:0] v);
        case (ad)
            ADDR_STATUS: s = v;
            ADDR_WORKING_ACCUMULATOR: w = v;
            ADDR_BSR: b = v;
            ADDR_PCL: begin
                pcm = {lu[4:0], lh, v};
                nop_next = 1'b1;
            end
            ADDR_LATH: lh = v;
            ADDR_LATU: lu = v;
            ADDR_EVT: evt = v;
            ADDR_CTRL: ctrl = v;
            default: mem[ad] = v;
        endcase
    endtask

    task automatic add_to(input logic [7:0] x, input logic to_file, input logic [11:0] ad);
        logic [8:0] sum;
        logic [4:0] fl;
        sum = {1'b0, w} + {1'b0, x};
        fl = {sum[7], (w[7] == x[7]) && (sum[7] != w[7]), sum[7:0] == 8'h00,
            ({1'b0, w[3:0]} + {1'b0, x[3:0]}) > 5'h0f, sum[8]};
        if (to_file) wrf(ad, sum[7:0]);
        else w = sum[7:0];
        s[4:0] = fl;
    endtask

    task automatic exec(input logic [15:0] wd);
        logic [11:0] ad;
        logic [7:0] v;
        ad = wd[A_BIT] ? {b[3:0], wd[7:0]} : {{4{wd[7]}}, wd[7:0]};
        cur = pcm;
        pcm = pcm + 21'h1;
        if (wd[15:8] == OPC_ADD_LIT) begin
            add_to(wd[7:0], 1'b0, ad);
        end else if (wd[15:10] == OPC_ADD_FILE) begin
            add_to(rdf(ad), wd[D_BIT], ad);
        end else if (wd[15:9] == OPC_CLEAR) begin
            wrf(ad, 8'h00);
            s[Z_POS] = 1'b1;
        end else if (wd[15:12] inside {OPC_BIT_SET, OPC_BIT_CLR, OPC_BIT_TGL}) begin
            v = rdf(ad);
            v[wd[11:9]] = (wd[15:12] == OPC_BIT_SET) ? 1'b1 :
                (wd[15:12] == OPC_BIT_CLR) ? 1'b0 : ~v[wd[11:9]];
            wrf(ad, v);
        end else if (wd[15:9] == OPC_CALL) begin
            ret = pcm;
            if (wd[CALL_S_BIT]) shadow = {w, b, s};
            pcm = {lu[4:0], lh, wd[7:0]};
            nop_next = 1'b1;
        end else if (wd[15:1] == OPC_RETURN || wd[15:1] == OPC_INT_RETURN) begin
            pcm = ret;
            if (wd[RET_S_BIT]) {w, b, s} = shadow;
            nop_next = 1'b1;
        end
    endtask

    task automatic wait_end();
        repeat (400) begin
            @(negedge I_CLK);
            if (O_PHASE === 2'd3) break;
        end
        repeat (400) begin
            @(negedge I_CLK);
            if (O_PHASE === 2'd0) break;
        end
    endtask

    task automatic do_cycle();
        int t0;
        logic irq_now, evt_now;
        t0 = clk_n;
        irq_now = (pcm == IRQ_PC) && !nop_next;
        evt_now = (pcm == EVT_PC) && !nop_next;
        `CHK("pc", pcm, O_PC)
        if (nop_next) begin
            nop_next = 1'b0;
        end else begin
            if (irq_now || evt_now) begin
                @(posedge I_CLK);
                I_IRQ <= irq_now;
                I_HW_EVT <= evt_now ? EVT_VAL : 8'h00;
                @(posedge I_CLK);
                I_IRQ <= 1'b0;
                I_HW_EVT <= 8'h00;
            end
            exec(u_mem.prog[pcm[7:0]]);
            if (evt_now) evt = evt | EVT_VAL;
            if (irq_now) begin
                ret = pcm;
                shadow = {w, b, s};
                pcm = IRQ_VECTOR;
                nop_next = 1'b1;
            end
        end
        wait_end();
        `CHK("working_accumulator", w, O_WORKING_ACCUMULATOR)
        `CHK("status", s, O_STATUS)
        if (!alt_prev && !ctrl[CTRL_ALT_BIT]) `CHK("clocks", 4, clk_n - t0)
        else if (alt_prev && ctrl[CTRL_ALT_BIT]) `CHK("alt", 1'b1, (clk_n - t0) > 4)
        alt_prev = ctrl[CTRL_ALT_BIT];
    endtask

    function automatic logic [15:0] rand_op(input logic [31:0] r);
        case (r[1:0])
            2'd0: return {OPC_ADD_LIT, r[15:8]};
            2'd1: return {OPC_ADD_FILE, r[9:8], 1'b0, r[22:16]};
            2'd2: return {r[3] ? OPC_BIT_SET : r[4] ? OPC_BIT_CLR : OPC_BIT_TGL,
                r[11:8], 1'b0, r[22:16]};
            default: return {OPC_CLEAR, r[8], 1'b0, r[22:16]};
        endcase
    endfunction

    task automatic put(input logic [15:0] wd);
        u_mem.prog[pa] = wd;
        pa++;
    endtask

    initial begin
        seed = 32'h7a1c584f;
        {I_RSTN, I_ALT_TICK, I_IRQ, I_HW_EVT, clk_n, alt_cnt, fail_count, cmp_count} = '0;
        {ack_seen, alt_prev, nop_next, w, s, b, lh, lu, evt, ctrl, pcm, ret, shadow} = '0;
        for (int i = 0; i < 256; i++) u_mem.prog[i] = NOP_WORD;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'($random(seed));
            u_mem.data[i] = mem[i];
        end
        pa = 0;
        put(16'h6ae0);
        repeat (12) put(rand_op($random(seed)));
        put(16'h6ae1);
        put(16'h0f20);
        put(16'h26e3);
        put(16'h0011);
        pa = 'h2f;
        foreach (build_a[i]) put(build_a[i]);
        repeat (2) put(rand_op($random(seed)));
        put(16'h6ae7);
        put({OPC_ADD_LIT, 8'($random(seed))});
        pa = 'h50;
        put({OPC_ADD_LIT, 8'($random(seed))});
        put(16'h26e0);
        put(16'h78e0);
        put(16'h0013);
        pa = 'h60;
        put(16'h0f11);
        put(16'h0012);
        repeat (12) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        @(negedge I_CLK);
        while (pcm != END_PC) do_cycle();
        `CHK("irq_ack", 1'b1, ack_seen)
        for (int i = 0; i < 4096; i++) `CHK("file", mem[i], u_mem.data[i])
        report_and_stop();
    end
endmodule
